// >>> src/fphi_host.v
// Behaviour
// - Host drives command/data bytes on writes
// - Chip select low for every access
// - Hold reset/power-down low through power transitions
// - Wait 620 ns after reset release
// - Program/erase use two write cycles
`timescale 1ns/1ns
`default_nettype none
`include "fphi_regs.vh"
module fphi_host (
  input  wire                     i_clk,
  input  wire                     i_sys_rst,
  input  wire                     i_pwr_good,
  input  wire                     i_powerdown,
  input  wire                     i_req,
  input  wire                     i_req_write,
  input  wire [`FPHI_ADDR_W-1:0]  i_req_addr,
  input  wire [`FPHI_DATA_W-1:0]  i_req_wdata,
  output reg                      o_req_ready,
  output reg                      o_rd_valid,
  output reg  [`FPHI_DATA_W-1:0]  o_rd_data,
  output reg                      o_dev_busy,
  output reg  [`FPHI_OFS_W-1:0]   o_byte_offset_addr,
  output reg  [`FPHI_BLK_W-1:0]   o_block_select_addr,
  output reg  [`FPHI_DATA_W-1:0]  o_data_io_bus,
  output reg                      o_data_io_bus_oe,
  input  wire [`FPHI_DATA_W-1:0]  i_data_io_bus,
  output reg                      o_chip_sel_n,
  output reg                      o_out_gate_n,
  output reg                      o_write_strobe_n,
  output reg                      o_reset_powerdown_n,
  input  wire                     i_ready_busy_n
);
  localparam [2:0] ST_OFF    = 3'h0;
  localparam [2:0] ST_RECOV  = 3'h1;
  localparam [2:0] ST_IDLE   = 3'h2;
  localparam [2:0] ST_SETUP  = 3'h3;
  localparam [2:0] ST_STROBE = 3'h4;
  localparam [2:0] ST_READ   = 3'h5;
  localparam [2:0] ST_HOLD   = 3'h6;

  wire [`FPHI_DATA_W-1:0] dq_s;
  wire [2:0]              ctl_s;
  fphi_sync #(.W(`FPHI_DATA_W + 3)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_data_io_bus, i_ready_busy_n, i_pwr_good, i_powerdown}),
    .o_sync    ({dq_s, ctl_s})
  );
  wire rb_s = ctl_s[2];
  wire pg_s = ctl_s[1];
  wire pd_s = ctl_s[0];

  reg [2:0]              st_r;
  reg [2:0]              st_nxt;
  reg [`FPHI_CNT_W-1:0]  cnt_r;
  reg [`FPHI_CNT_W-1:0]  cnt_nxt;
  reg                    wr_r;
  reg                    wr_nxt;
  reg                    req_ready_nxt;
  reg                    rd_valid_nxt;
  reg [`FPHI_DATA_W-1:0] rd_data_nxt;
  reg                    dev_busy_nxt;
  reg [`FPHI_OFS_W-1:0]  ofs_nxt;
  reg [`FPHI_BLK_W-1:0]  blk_nxt;
  reg [`FPHI_DATA_W-1:0] dq_out_nxt;
  reg                    dq_oe_nxt;
  reg                    cs_n_nxt;
  reg                    oe_n_nxt;
  reg                    we_n_nxt;
  reg                    rp_n_nxt;
  wire                   cnt_last;
  wire                   supply_ok;

  assign cnt_last  = (cnt_r == `FPHI_CNT_ONE);
  assign supply_ok = pg_s & ~pd_s;

  // Next values; every pin and status output is registered below
  always @* begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    wr_nxt        = wr_r;
    req_ready_nxt = o_req_ready;
    rd_valid_nxt  = 1'b0;
    rd_data_nxt   = o_rd_data;
    dev_busy_nxt  = ~rb_s & o_reset_powerdown_n;
    ofs_nxt       = o_byte_offset_addr;
    blk_nxt       = o_block_select_addr;
    dq_out_nxt    = o_data_io_bus;
    dq_oe_nxt     = o_data_io_bus_oe;
    cs_n_nxt      = o_chip_sel_n;
    oe_n_nxt      = o_out_gate_n;
    we_n_nxt      = o_write_strobe_n;
    rp_n_nxt      = o_reset_powerdown_n;
    if (!supply_ok) begin
      // Power unstable or deep power-down requested: abort, hold device in reset
      st_nxt        = ST_OFF;
      rp_n_nxt      = `FPHI_PIN_ACT;
      req_ready_nxt = 1'b0;
      cs_n_nxt      = `FPHI_PIN_IDLE;
      oe_n_nxt      = `FPHI_PIN_IDLE;
      we_n_nxt      = `FPHI_PIN_IDLE;
      dq_oe_nxt     = 1'b0;
    end else begin
      case (st_r)
        ST_OFF: begin
          rp_n_nxt = `FPHI_PIN_IDLE;
          cnt_nxt  = `FPHI_RECOVER_CYC;
          st_nxt   = ST_RECOV;
        end
        ST_RECOV: begin
          // No access until the device's internal circuits are up again
          cnt_nxt = cnt_r - `FPHI_CNT_ONE;
          if (cnt_last) begin
            req_ready_nxt = 1'b1;
            st_nxt        = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (i_req) begin
            req_ready_nxt = 1'b0;
            wr_nxt        = i_req_write;
            ofs_nxt       = i_req_addr[`FPHI_OFS_W-1:0];
            blk_nxt       = i_req_addr[`FPHI_ADDR_W-1:`FPHI_OFS_W];
            dq_out_nxt    = i_req_wdata;
            dq_oe_nxt     = i_req_write;
            cs_n_nxt      = `FPHI_PIN_ACT;
            cnt_nxt       = `FPHI_SETUP_CYC;
            st_nxt        = ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_nxt = cnt_r - `FPHI_CNT_ONE;
          if (cnt_last) begin
            if (wr_r) begin
              we_n_nxt = `FPHI_PIN_ACT;
              cnt_nxt  = `FPHI_STROBE_CYC;
              st_nxt   = ST_STROBE;
            end else begin
              // Host side of the bus is already off, so the device may drive it
              oe_n_nxt = `FPHI_PIN_ACT;
              cnt_nxt  = `FPHI_READ_CYC;
              st_nxt   = ST_READ;
            end
          end
        end
        ST_STROBE: begin
          cnt_nxt = cnt_r - `FPHI_CNT_ONE;
          if (cnt_last) begin
            // Address and data stay put across the rising edge
            we_n_nxt = `FPHI_PIN_IDLE;
            cnt_nxt  = `FPHI_HOLD_CYC;
            st_nxt   = ST_HOLD;
          end
        end
        ST_READ: begin
          cnt_nxt = cnt_r - `FPHI_CNT_ONE;
          if (cnt_last) begin
            rd_data_nxt  = dq_s;
            rd_valid_nxt = 1'b1;
            oe_n_nxt     = `FPHI_PIN_IDLE;
            cnt_nxt      = `FPHI_HOLD_CYC;
            st_nxt       = ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_nxt = cnt_r - `FPHI_CNT_ONE;
          if (cnt_last) begin
            cs_n_nxt      = `FPHI_PIN_IDLE;
            dq_oe_nxt     = 1'b0;
            req_ready_nxt = 1'b1;
            st_nxt        = ST_IDLE;
          end
        end
        default: begin
          st_nxt = ST_OFF;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r                <= ST_OFF;
      cnt_r               <= `FPHI_CNT_ZERO;
      wr_r                <= 1'b0;
      o_req_ready         <= 1'b0;
      o_rd_valid          <= 1'b0;
      o_rd_data           <= {`FPHI_DATA_W{1'b0}};
      o_dev_busy          <= 1'b0;
      o_byte_offset_addr  <= {`FPHI_OFS_W{1'b0}};
      o_block_select_addr <= {`FPHI_BLK_W{1'b0}};
      o_data_io_bus       <= {`FPHI_DATA_W{1'b0}};
      o_data_io_bus_oe    <= 1'b0;
      o_chip_sel_n        <= `FPHI_PIN_IDLE;
      o_out_gate_n        <= `FPHI_PIN_IDLE;
      o_write_strobe_n    <= `FPHI_PIN_IDLE;
      o_reset_powerdown_n <= `FPHI_PIN_ACT;
    end else begin
      st_r                <= st_nxt;
      cnt_r               <= cnt_nxt;
      wr_r                <= wr_nxt;
      o_req_ready         <= req_ready_nxt;
      o_rd_valid          <= rd_valid_nxt;
      o_rd_data           <= rd_data_nxt;
      o_dev_busy          <= dev_busy_nxt;
      o_byte_offset_addr  <= ofs_nxt;
      o_block_select_addr <= blk_nxt;
      o_data_io_bus       <= dq_out_nxt;
      o_data_io_bus_oe    <= dq_oe_nxt;
      o_chip_sel_n        <= cs_n_nxt;
      o_out_gate_n        <= oe_n_nxt;
      o_write_strobe_n    <= we_n_nxt;
      o_reset_powerdown_n <= rp_n_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> src/fphi_regs.vh
`ifndef FPHI_REGS_VH
`define FPHI_REGS_VH
`define FPHI_ADDR_W        19
`define FPHI_OFS_W         14
`define FPHI_BLK_W         5
`define FPHI_DATA_W        8
`define FPHI_CLK_PERIOD_NS 8
`define FPHI_RECOVER_NS    620
// Recovery in clock cycles, rounded up
`define FPHI_RECOVER_CYC   8'h4E
`define FPHI_SETUP_CYC     8'h04
`define FPHI_STROBE_CYC    8'h08
`define FPHI_READ_CYC      8'h14
`define FPHI_HOLD_CYC      8'h02
`define FPHI_PIN_ACT       1'b0
`define FPHI_PIN_IDLE      1'b1
`define FPHI_CNT_W         8
`define FPHI_CNT_ONE       8'h01
`define FPHI_CNT_ZERO      8'h00
`endif

// >>> src/fphi_sync.v
`timescale 1ns/1ns
`default_nettype none
module fphi_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta_r;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> dv/fphi_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "fphi_regs.vh"
module fphi_chk (
  input wire logic                    i_clk,
  input wire logic                    i_sys_rst,
  input wire logic                    i_pwr_good,
  input wire logic                    o_req_ready,
  input wire logic                    o_rd_valid,
  input wire logic                    o_dev_busy,
  input wire logic [`FPHI_OFS_W-1:0]  o_byte_offset_addr,
  input wire logic [`FPHI_BLK_W-1:0]  o_block_select_addr,
  input wire logic [`FPHI_DATA_W-1:0] o_data_io_bus,
  input wire logic                    o_data_io_bus_oe,
  input wire logic                    o_chip_sel_n,
  input wire logic                    o_out_gate_n,
  input wire logic                    o_write_strobe_n,
  input wire logic                    o_reset_powerdown_n
);
  logic [7:0] rc_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Cycles since the device left power-down
  always @(posedge i_clk) begin
    rc_r <= !o_reset_powerdown_n ? 8'h00 : (rc_r == 8'hFF ? rc_r : rc_r + 8'h01);
  end
  a_unsel_float: assert property (o_chip_sel_n |-> !o_data_io_bus_oe)
    else $error("bus driven while unselected");
  a_read_float: assert property (!o_out_gate_n |-> !o_data_io_bus_oe)
    else $error("host drives during read");
  a_strobe_sel: assert property (!o_out_gate_n || !o_write_strobe_n |-> !o_chip_sel_n)
    else $error("strobe without select");
  a_strobe_data: assert property ($fell(o_write_strobe_n) |-> o_data_io_bus_oe && o_out_gate_n)
    else $error("write without data");
  a_strobe_width: assert property ($fell(o_write_strobe_n) |-> !o_write_strobe_n [*8] ##1 o_write_strobe_n)
    else $error("strobe width");
  a_latch_stable: assert property ($rose(o_write_strobe_n) |-> o_data_io_bus_oe &&
    $stable(o_byte_offset_addr) && $stable(o_block_select_addr) && $stable(o_data_io_bus))
    else $error("pins moved at latch");
  a_pwr_hold: assert property (!i_pwr_good [*4] |-> !o_reset_powerdown_n)
    else $error("reset released on bad supply");
  a_recover_wait: assert property (o_req_ready |-> rc_r >= 8'h4D)
    else $error("access before recovery");
  a_access_wait: assert property ($fell(o_chip_sel_n) |-> rc_r >= `FPHI_RECOVER_CYC)
    else $error("select too soon after reset");
  a_rd_gate: assert property (o_rd_valid |-> !$past(o_out_gate_n))
    else $error("read without gate");
  c_read: cover property (o_rd_valid);
  c_write: cover property ($fell(o_write_strobe_n));
  c_busy: cover property (o_dev_busy);
endmodule
`default_nettype wire

// >>> dv/fphi_dev.sv
`timescale 1ns/1ns
`default_nettype none
module fphi_dev #(
  parameter logic [7:0] PROG = 8'h40
) (
  input wire logic [18:0] i_addr,
  input wire logic [7:0]  i_dq,
  input wire logic        i_ce_n,
  input wire logic        i_oe_n,
  input wire logic        i_we_n,
  input wire logic        i_rp_n,
  output var logic [7:0]  o_dq,
  output var logic        o_dq_oe,
  output var logic        o_busy_oe
);
  logic [7:0] mem [0:524287];
  logic       pend = 0;
  initial begin
    o_busy_oe = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  assign o_dq_oe = !i_ce_n && !i_oe_n && i_we_n && i_rp_n;
  assign o_dq = mem[i_addr];
  always @(posedge i_we_n) begin
    if (i_rp_n && !i_ce_n) begin
      if (pend) begin
        mem[i_addr] = i_dq;
        o_busy_oe = 1;
      end
      pend = !pend && i_dq === PROG;
    end
  end
  always @(posedge o_busy_oe) begin
    #400;
    o_busy_oe = 0;
  end
  always @(negedge i_rp_n) begin
    o_busy_oe = 0;
    pend = 0;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fphi_regs.vh"
module tb_top;
  logic clk = 0, rst = 1, pg = 1, pd = 0, req = 0, wr = 0;
  logic [18:0] adr = 0;
  logic [7:0] wd = 0, rdd, ddq, hdq, dq;
  logic rv, rdy, bsy, hoe, doe, boe, cs_n, oe_n, we_n, rp_n;
  logic [13:0] ofs;
  logic [4:0] blk;
  int error_cnt = 0, n_compared = 0;
  always #4 clk = ~clk;
  assign dq = hoe ? hdq : doe ? ddq : 8'hFF;
  fphi_host fphi_host_inst(.i_clk(clk), .i_sys_rst(rst), .i_pwr_good(pg), .i_powerdown(pd),
    .i_req(req), .i_req_write(wr), .i_req_addr(adr), .i_req_wdata(wd), .o_req_ready(rdy),
    .o_rd_valid(rv), .o_rd_data(rdd), .o_dev_busy(bsy), .o_byte_offset_addr(ofs),
    .o_block_select_addr(blk), .o_data_io_bus(hdq), .o_data_io_bus_oe(hoe),
    .i_data_io_bus(dq), .o_chip_sel_n(cs_n), .o_out_gate_n(oe_n), .o_write_strobe_n(we_n),
    .o_reset_powerdown_n(rp_n), .i_ready_busy_n(!boe));
  fphi_dev fphi_dev_inst(.i_addr({blk, ofs}), .i_dq(dq), .i_ce_n(cs_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_rp_n(rp_n), .o_dq(ddq), .o_dq_oe(doe), .o_busy_oe(boe));
  task chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic req_op(input logic w, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(rdy === 1'b1, "ready timeout");
    {wr, adr, wd} = {w, a, d};
    req = 1;
    @(negedge clk);
    req = 0;
    n = 0;
    while (!w && rv !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
    req_op(0, a, 8'h00);
    chk(rv === 1'b1 && rdd === e, "read data");
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (bsy !== v && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(bsy === v, "busy flag");
  endtask
  task t_prog;
    logic [18:0] pa [2];
    logic [7:0] pv [2];
    pa = '{19'h7FFFF, 19'h04000};
    pv = '{8'hA5, 8'h5A};
    foreach (pa[i]) begin
      rd_chk(pa[i], 8'hFF);
      req_op(1, pa[i], 8'h40);
      req_op(1, pa[i], pv[i]);
      wait_busy(1);
      wait_busy(0);
      rd_chk(pa[i], pv[i]);
    end
    rd_chk(19'h3FFFF, 8'hFF);
  endtask
  task t_pd;
    req_op(1, 19'h00123, 8'h40);
    req_op(1, 19'h00123, 8'h77);
    wait_busy(1);
    req_op(1, 19'h00200, 8'h40);
    rd_chk(19'h00200, 8'hFF);
    pd = 1;
    repeat (4) @(negedge clk);
    chk(rp_n === 1'b0 && rdy === 1'b0, "no power-down");
    pd = 0;
    pg = 0;
    repeat (6) @(negedge clk);
    chk(rp_n === 1'b0 && bsy === 1'b0, "busy kept");
    pg = 1;
    req_op(1, 19'h00200, 8'h99);
    rd_chk(19'h00200, 8'hFF);
    rd_chk(19'h00124, 8'hFF);
  endtask
  task final_report;
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    t_prog;
    t_pd;
    final_report;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule
bind fphi_host fphi_chk fphi_chk_inst(
  .i_clk               (i_clk),
  .i_sys_rst           (i_sys_rst),
  .i_pwr_good          (i_pwr_good),
  .o_req_ready         (o_req_ready),
  .o_rd_valid          (o_rd_valid),
  .o_dev_busy          (o_dev_busy),
  .o_byte_offset_addr  (o_byte_offset_addr),
  .o_block_select_addr (o_block_select_addr),
  .o_data_io_bus       (o_data_io_bus),
  .o_data_io_bus_oe    (o_data_io_bus_oe),
  .o_chip_sel_n        (o_chip_sel_n),
  .o_out_gate_n        (o_out_gate_n),
  .o_write_strobe_n    (o_write_strobe_n),
  .o_reset_powerdown_n (o_reset_powerdown_n)
);
`default_nettype wire
